// [cmfs_pkg.sv]
`default_nettype none
package cmfs_pkg;
	// Serial frame layout, MSB first
	localparam int          FRAME_BITS   = 32;
	localparam logic [4:0]  LAST_BIT_CNT = 5'h1f;
	localparam logic [11:0] FRAME_HEADER = 12'h001;
	localparam int          HEADER_MSB   = 31;
	localparam int          HEADER_LSB   = 20;
	localparam int          ADDR_MSB     = 19;
	localparam int          ADDR_LSB     = 16;
	localparam int          DATA_MSB     = 15;

	// Register addresses
	localparam logic [3:0] ADDR_OUTPUT_CONFIGURATION  = 4'h1;
	localparam logic [3:0] ADDR_I_CHANNEL_OFFSET      = 4'h2;
	localparam logic [3:0] ADDR_I_CHANNEL_RANGE       = 4'h3;
	localparam logic [3:0] ADDR_EXTENDED_CONFIGURATION = 4'h9;
	localparam logic [3:0] ADDR_Q_CHANNEL_OFFSET      = 4'ha;
	localparam logic [3:0] ADDR_Q_CHANNEL_RANGE       = 4'hb;
	localparam logic [3:0] ADDR_SAMPLE_PHASE_FINE     = 4'he;
	localparam logic [3:0] ADDR_SAMPLE_PHASE_COARSE   = 4'hf;

	// Output configuration fields
	localparam int SECOND_CLOCK_DISABLE_LOW_BIT = 13;
	localparam int OUTPUT_DATA_CLOCK_PHASE_SELECT_BIT        = 11;
	localparam int DDR_SELECT_LOW_BIT           = 10;
	localparam int OUTPUT_AMPLITUDE_SELECT_BIT  = 9;
	localparam int OUTPUT_EDGE_DEMUX_SELECT_BIT = 8;

	// Extended configuration fields
	localparam int TEST_PATTERN_OUTPUT_BIT      = 15;
	localparam int RESISTOR_TRIM_DISABLE_BIT    = 14;
	localparam int DUAL_EDGE_SAMPLING_ENABLE_BIT = 13;
	localparam int DUAL_EDGE_Q_INPUT_BIT        = 12;

	// Adjust fields
	localparam int ADJUST_LSB = 7;
	localparam int FINE_LSB   = 8;

	// Power-on values
	localparam logic [15:0] OUTPUT_CONFIGURATION_RESET   = 16'hb2ff;
	localparam logic [15:0] EXTENDED_CONFIGURATION_RESET = 16'h0000;
	localparam logic [15:0] OFFSET_RESET                 = 16'h0000;
	localparam logic [15:0] RANGE_RESET                  = 16'h8000;
	localparam logic [15:0] PHASE_RESET                  = 16'h0000;

	typedef enum logic [1:0] {
		RX_IDLE   = 2'b00,
		RX_SHIFT  = 2'b01,
		RX_COMMIT = 2'b10
	} cmfs_rx_state_type;

	typedef struct packed {
		logic       ext_mode;
		logic       ddr_enable;
		logic       output_data_clock_phase_select;
		logic       sdr_data_on_rising;
		logic       amplitude_normal;
		logic       cal_delay_long;
		logic       range_reduced;
		logic       dual_edge_sampling_enable;
		logic       dual_edge_q_input;
		logic       test_pattern_output;
		logic       output_data_clock_continuous;
		logic       demux_1to2;
		logic       second_output_data_clock_enable;
		logic [8:0] range_i;
		logic [8:0] range_q;
		logic [8:0] offset_i;
		logic [8:0] offset_q;
		logic [8:0] phase_coarse_mid;
		logic [7:0] phase_fine;
	} cmfs_options_type;

	typedef struct packed {
		logic sclk;
		logic sdata;
		logic scs_low;
		logic ctrl_mode_low;
		logic ddr_strap_mid;
		logic ddr_strap_high;
		logic amplitude_strap;
		logic cal_strap_mid;
		logic cal_strap_high;
		logic range_strap;
	} cmfs_pins_type;
endpackage
`default_nettype wire

// [cmfs_feature_select.sv]
// Summary of operation
// - Strap picks SDR/DDR in pin mode; active-low bit 10 of 1h otherwise.
// - DDR clock phase fixed at zero in pin mode; bit 11 of 1h otherwise.
// - Pin-mode SDR data changes on rising edge if strap high, else falling.
// - Extended mode: bit 8 of 1h picks the SDR data edge.
// - Amplitude strap high normal, low reduced; extended uses bit 9 of 1h.
// - Pin mode: calibration delay from strap; extended mode: short only.
// - Range strap high normal, low reduced, same for both channels.
// - Extended: per-channel 9-bit range, registers 3h and Bh bits 15..7.
// - Offset only in extended: registers 2h and Ah bits 15..7.
// - Pin mode: mid-level strap enables dual-edge sampling on I input only.
// - Extended: bit 13 of 9h enables dual-edge; I or Q input selectable.
// - Test pattern only in extended mode with bit 15 of 9h set.
// - Extended: trim-disable bit keeps output clock running; not in pin mode.
// - Extended DDR: edge/demux bit one gives 1:1, zero gives 1:2.
// - Extended: active-low bit 13 of 1h turns range pair into second clock.
// - Sampling phase only in extended: Fh bits 15..7, Eh bits 15..8.
// - Reset loads DDR, zero phase, normal swing, short delay, nominal adjusts.
// - Reset: no dual-edge, no pattern, trim on, 1:2, range pins, no phase.
// - Registers have no effect while pin mode is selected.
`timescale 1ns/100ps
`default_nettype none
module cmfs_feature_select (
	input  wire logic                      clk,
	input  wire logic                      resetn,
	input  wire logic                      sclk,
	input  wire logic                      sdata,
	input  wire logic                      scs_low,
	input  wire logic                      ctrl_mode_low,
	input  wire logic                      ddr_strap_mid,
	input  wire logic                      ddr_strap_high,
	input  wire logic                      amplitude_strap,
	input  wire logic                      cal_strap_mid,
	input  wire logic                      cal_strap_high,
	input  wire logic                      range_strap,
	output logic                           reg_write_q,
	output logic                           header_error_q,
	output cmfs_pkg::cmfs_options_type     options_q
);
	cmfs_pkg::cmfs_pins_type     pins_raw;
	cmfs_pkg::cmfs_pins_type     meta_q;
	cmfs_pkg::cmfs_pins_type     pins_s;
	logic                        sclk_prev_q;
	logic                        sclk_rise;
	logic                        mode_ext;
	logic [31:0]                 shift_q;
	logic [4:0]                  bit_cnt_q;
	cmfs_pkg::cmfs_rx_state_type state_q;
	cmfs_pkg::cmfs_rx_state_type state_d;
	logic                        header_ok;
	logic                        commit;
	logic [3:0]                  frame_addr;
	logic [15:0]                 frame_data;
	logic [15:0]                 ocfg_q;
	logic [15:0]                 ecfg_q;
	logic [15:0]                 offset_i_q;
	logic [15:0]                 range_i_q;
	logic [15:0]                 offset_q_q;
	logic [15:0]                 range_q_q;
	logic [15:0]                 phase_fine_q;
	logic [15:0]                 phase_coarse_q;
	cmfs_pkg::cmfs_options_type  options_d;

	assign pins_raw = '{sclk: sclk, sdata: sdata, scs_low: scs_low,
		ctrl_mode_low: ctrl_mode_low, ddr_strap_mid: ddr_strap_mid,
		ddr_strap_high: ddr_strap_high, amplitude_strap: amplitude_strap,
		cal_strap_mid: cal_strap_mid, cal_strap_high: cal_strap_high,
		range_strap: range_strap};

	// Two-stage synchroniser for every pin
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			// Select held at its idle level, so no false frame start
			meta_q         <= '0;
			meta_q.scs_low <= 1'b1;
			pins_s         <= '0;
			pins_s.scs_low <= 1'b1;
		end else begin
			meta_q <= pins_raw;
			pins_s <= meta_q;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sclk_prev_q <= 1'b0;
		end else begin
			sclk_prev_q <= pins_s.sclk;
		end
	end

	assign sclk_rise = pins_s.sclk & ~sclk_prev_q;
	assign mode_ext  = ~pins_s.ctrl_mode_low;

	// Serial shift and bit count; deselect restarts the frame
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			shift_q   <= '0;
			bit_cnt_q <= '0;
		end else if (pins_s.scs_low) begin
			bit_cnt_q <= '0;
		end else if (sclk_rise) begin
			shift_q   <= {shift_q[30:0], pins_s.sdata};
			bit_cnt_q <= bit_cnt_q + 5'h01;
		end
	end

	always_comb begin
		state_d = state_q;
		case (state_q)
			cmfs_pkg::RX_IDLE: begin
				if (!pins_s.scs_low && mode_ext) begin
					state_d = cmfs_pkg::RX_SHIFT;
				end
			end
			cmfs_pkg::RX_SHIFT: begin
				if (pins_s.scs_low || !mode_ext) begin
					state_d = cmfs_pkg::RX_IDLE;
				end else if (sclk_rise &&
						bit_cnt_q == cmfs_pkg::LAST_BIT_CNT) begin
					state_d = cmfs_pkg::RX_COMMIT;
				end
			end
			cmfs_pkg::RX_COMMIT: begin
				state_d = cmfs_pkg::RX_SHIFT;
			end
			default: begin
				state_d = cmfs_pkg::RX_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_q <= cmfs_pkg::RX_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	assign header_ok  = shift_q[cmfs_pkg::HEADER_MSB:cmfs_pkg::HEADER_LSB]
		== cmfs_pkg::FRAME_HEADER;
	assign frame_addr = shift_q[cmfs_pkg::ADDR_MSB:cmfs_pkg::ADDR_LSB];
	assign frame_data = shift_q[cmfs_pkg::DATA_MSB:0];
	// Whole frame received before any register changes
	assign commit = state_q == cmfs_pkg::RX_COMMIT && header_ok
		&& mode_ext;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			reg_write_q    <= 1'b0;
			header_error_q <= 1'b0;
		end else begin
			reg_write_q    <= commit;
			header_error_q <= state_q == cmfs_pkg::RX_COMMIT && !header_ok;
		end
	end

	// Write-only register bank, power-on defaults
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ocfg_q         <= cmfs_pkg::OUTPUT_CONFIGURATION_RESET;
			ecfg_q         <= cmfs_pkg::EXTENDED_CONFIGURATION_RESET;
			offset_i_q     <= cmfs_pkg::OFFSET_RESET;
			offset_q_q     <= cmfs_pkg::OFFSET_RESET;
			range_i_q      <= cmfs_pkg::RANGE_RESET;
			range_q_q      <= cmfs_pkg::RANGE_RESET;
			phase_fine_q   <= cmfs_pkg::PHASE_RESET;
			phase_coarse_q <= cmfs_pkg::PHASE_RESET;
		end else if (commit) begin
			case (frame_addr)
				cmfs_pkg::ADDR_OUTPUT_CONFIGURATION: begin
					ocfg_q <= frame_data;
				end
				cmfs_pkg::ADDR_EXTENDED_CONFIGURATION: begin
					ecfg_q <= frame_data;
				end
				cmfs_pkg::ADDR_I_CHANNEL_OFFSET: begin
					offset_i_q <= frame_data;
				end
				cmfs_pkg::ADDR_Q_CHANNEL_OFFSET: begin
					offset_q_q <= frame_data;
				end
				cmfs_pkg::ADDR_I_CHANNEL_RANGE: begin
					range_i_q <= frame_data;
				end
				cmfs_pkg::ADDR_Q_CHANNEL_RANGE: begin
					range_q_q <= frame_data;
				end
				cmfs_pkg::ADDR_SAMPLE_PHASE_FINE: begin
					phase_fine_q <= frame_data;
				end
				cmfs_pkg::ADDR_SAMPLE_PHASE_COARSE: begin
					phase_coarse_q <= frame_data;
				end
				default: begin
				end
			endcase
		end
	end

	// Option selection by control mode
	always_comb begin
		options_d          = '0;
		options_d.ext_mode = mode_ext;
		options_d.range_i  = cmfs_pkg::RANGE_RESET[15:7];
		options_d.range_q  = cmfs_pkg::RANGE_RESET[15:7];
		if (mode_ext) begin
			options_d.ddr_enable =
				~ocfg_q[cmfs_pkg::DDR_SELECT_LOW_BIT];
			options_d.output_data_clock_phase_select =
				ocfg_q[cmfs_pkg::OUTPUT_DATA_CLOCK_PHASE_SELECT_BIT];
			options_d.sdr_data_on_rising =
				ocfg_q[cmfs_pkg::OUTPUT_EDGE_DEMUX_SELECT_BIT];
			options_d.amplitude_normal =
				ocfg_q[cmfs_pkg::OUTPUT_AMPLITUDE_SELECT_BIT];
			options_d.cal_delay_long = 1'b0;
			options_d.range_i =
				range_i_q[15:cmfs_pkg::ADJUST_LSB];
			options_d.range_q =
				range_q_q[15:cmfs_pkg::ADJUST_LSB];
			options_d.offset_i =
				offset_i_q[15:cmfs_pkg::ADJUST_LSB];
			options_d.offset_q =
				offset_q_q[15:cmfs_pkg::ADJUST_LSB];
			options_d.dual_edge_sampling_enable =
				ecfg_q[cmfs_pkg::DUAL_EDGE_SAMPLING_ENABLE_BIT];
			options_d.dual_edge_q_input =
				ecfg_q[cmfs_pkg::DUAL_EDGE_Q_INPUT_BIT];
			options_d.test_pattern_output =
				ecfg_q[cmfs_pkg::TEST_PATTERN_OUTPUT_BIT];
			options_d.output_data_clock_continuous =
				ecfg_q[cmfs_pkg::RESISTOR_TRIM_DISABLE_BIT];
			options_d.demux_1to2 = ~(options_d.ddr_enable &&
				ocfg_q[cmfs_pkg::OUTPUT_EDGE_DEMUX_SELECT_BIT]);
			options_d.second_output_data_clock_enable =
				~ocfg_q[cmfs_pkg::SECOND_CLOCK_DISABLE_LOW_BIT];
			options_d.phase_coarse_mid =
				phase_coarse_q[15:cmfs_pkg::ADJUST_LSB];
			options_d.phase_fine =
				phase_fine_q[15:cmfs_pkg::FINE_LSB];
		end else begin
			// Registers ignored; straps alone decide
			options_d.ddr_enable = pins_s.ddr_strap_mid;
			options_d.output_data_clock_phase_select = 1'b0;
			options_d.sdr_data_on_rising = pins_s.ddr_strap_high;
			options_d.amplitude_normal = pins_s.amplitude_strap;
			options_d.cal_delay_long = pins_s.cal_strap_high
				& ~pins_s.cal_strap_mid;
			options_d.range_reduced = ~pins_s.range_strap;
			options_d.dual_edge_sampling_enable =
				pins_s.cal_strap_mid;
			options_d.dual_edge_q_input = 1'b0;
			options_d.demux_1to2 = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			options_q                  <= '0;
			options_q.ddr_enable       <= 1'b1;
			options_q.amplitude_normal <= 1'b1;
			options_q.demux_1to2       <= 1'b1;
			options_q.range_i          <= cmfs_pkg::RANGE_RESET[15:7];
			options_q.range_q          <= cmfs_pkg::RANGE_RESET[15:7];
		end else begin
			options_q <= options_d;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);

	chk_pin_mode_locks: assert property (
		!mode_ext |=> !options_q.test_pattern_output
			&& !options_q.output_data_clock_continuous && options_q.offset_i == '0
			&& options_q.offset_q == '0 && !options_q.second_output_data_clock_enable
			&& options_q.phase_fine == '0 && options_q.demux_1to2)
		else $error("pin mode leaked a register option");
	chk_ddr_ext_select: assert property (
		mode_ext |=> options_q.ddr_enable
			== !$past(ocfg_q[cmfs_pkg::DDR_SELECT_LOW_BIT]))
		else $error("extended ddr select wrong");
	chk_ddr_strap_select: assert property (
		!mode_ext |=> options_q.ddr_enable == $past(pins_s.ddr_strap_mid)
			&& options_q.sdr_data_on_rising
			== $past(pins_s.ddr_strap_high))
		else $error("strap ddr or edge wrong");
	chk_demux_select: assert property (
		mode_ext |=> options_q.demux_1to2
			== !(!$past(ocfg_q[cmfs_pkg::DDR_SELECT_LOW_BIT])
			&& $past(ocfg_q[cmfs_pkg::OUTPUT_EDGE_DEMUX_SELECT_BIT])))
		else $error("demux select wrong");
	chk_second_output_data_clock: assert property (
		mode_ext |=> options_q.second_output_data_clock_enable
			== !$past(ocfg_q[cmfs_pkg::SECOND_CLOCK_DISABLE_LOW_BIT]))
		else $error("second clock select wrong");
	chk_dual_edge_pin: assert property (
		!mode_ext && pins_s.cal_strap_mid |=>
			options_q.dual_edge_sampling_enable
			&& !options_q.dual_edge_q_input && !options_q.cal_delay_long)
		else $error("strap dual edge wrong");
	chk_write_whole_frame: assert property (
		$changed(ocfg_q) || $changed(range_i_q) || $changed(ecfg_q)
			|-> $past(state_q) == cmfs_pkg::RX_COMMIT
			&& $past(bit_cnt_q, 2) == cmfs_pkg::LAST_BIT_CNT)
		else $error("register changed before frame end");
	chk_commit_pulse: assert property (
		commit |=> reg_write_q ##1 !reg_write_q)
		else $error("write pulse not one cycle");
	chk_range_ext: assert property (
		mode_ext ##1 mode_ext |-> options_q.range_q
			== $past(range_q_q[15:cmfs_pkg::ADJUST_LSB])
			&& !options_q.range_reduced)
		else $error("extended range wrong");
	chk_test_pattern: assert property (
		options_q.test_pattern_output |-> $past(mode_ext)
			&& $past(ecfg_q[cmfs_pkg::TEST_PATTERN_OUTPUT_BIT]))
		else $error("test pattern without enable");
	chk_amplitude_select: assert property (
		!mode_ext |=> options_q.amplitude_normal
			== $past(pins_s.amplitude_strap))
		else $error("strap amplitude wrong");
	chk_ext_cal_range: assert property (
		mode_ext |=> !options_q.cal_delay_long && !options_q.range_reduced
			&& options_q.amplitude_normal
			== $past(ocfg_q[cmfs_pkg::OUTPUT_AMPLITUDE_SELECT_BIT]))
		else $error("extended delay or amplitude wrong");
	chk_pin_phase_zero: assert property (
		!mode_ext |=> !options_q.output_data_clock_phase_select && !options_q.ext_mode
			&& !options_q.range_reduced == $past(pins_s.range_strap))
		else $error("strap phase or range wrong");
	// Bad header must flag and leave registers 1h, 9h and Bh alone
	chk_bad_header_drop: assert property (
		state_q == cmfs_pkg::RX_COMMIT && !header_ok |=> header_error_q
			&& $stable(ocfg_q) && $stable(ecfg_q) && $stable(range_q_q))
		else $error("bad header frame was stored");

	cov_config_write: cover property (
		reg_write_q && $past(frame_addr)
			== cmfs_pkg::ADDR_OUTPUT_CONFIGURATION);
	cov_back_to_back: cover property (
		reg_write_q ##[1:300] reg_write_q);
	cov_bad_header: cover property (header_error_q);
	cov_pin_dual_edge: cover property (
		!options_q.ext_mode && options_q.dual_edge_sampling_enable);
endmodule
`default_nettype wire

// [cmfs_host_model.sv]
`timescale 1ns/100ps
`default_nettype none
module cmfs_host_model (
	input  wire logic clk,
	output logic      sclk,
	output logic      sdata,
	output logic      scs_low
);
	initial begin
		sclk = 1'b0;
		sdata = 1'b1;
		scs_low = 1'b1;
	end

	task automatic hold(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// Sends the top n bits MSB first; keep leaves select low for a follow-on
	task automatic send(input logic [31:0] f, input int n, input bit keep);
		for (int i = 31; i > 31 - n; i--) begin
			sdata = f[i];
			scs_low = 1'b0;
			hold(4);
			sclk = 1'b1;
			hold(4);
			sclk = 1'b0;
		end
		if (!keep) begin
			scs_low = 1'b1;
			// Released line shows no stale data
			sdata = ~sdata;
		end
	endtask
endmodule
`default_nettype wire

// [control_mode_feature_select_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module control_mode_feature_select_tb;
	logic                       clk;
	logic                       resetn;
	logic                       sclk;
	logic                       sdata;
	logic                       scs_low;
	logic                       ctrl_mode_low;
	logic                       ddr_strap_mid;
	logic                       ddr_strap_high;
	logic                       amplitude_strap;
	logic                       cal_strap_mid;
	logic                       cal_strap_high;
	logic                       range_strap;
	logic                       reg_write_q;
	logic                       header_error_q;
	cmfs_pkg::cmfs_options_type options_q;
	cmfs_pkg::cmfs_options_type exp_o;
	cmfs_pkg::cmfs_options_type got_o;
	logic [15:0]                sh [16];
	logic [15:0]                cfg1 [4] = '{16'h9dff, 16'hbbff, 16'hb6ff,
		16'hb2ff};
	logic [15:0]                cfg9 [5] = '{16'h8000, 16'h4000, 16'h2000,
		16'h3000, 16'h0000};
	logic [3:0]                 adr [6] = '{4'h2, 4'ha, 4'h3, 4'hb, 4'he,
		4'hf};
	logic [15:0]                adj [6] = '{16'hff80, 16'h0080, 16'h0000,
		16'h7f80, 16'habff, 16'h5555};
	logic [5:0]                 straps [3] = '{6'b101011, 6'b010110,
		6'b001000};
	int                         fail_count;
	int                         tests_run;
	int                         wr_cnt;
	int                         err_cnt;
	int                         exp_wr;
	int                         cyc;

	cmfs_feature_select cmfs_feature_select_inst (
		.clk(clk), .resetn(resetn), .sclk(sclk), .sdata(sdata),
		.scs_low(scs_low), .ctrl_mode_low(ctrl_mode_low),
		.ddr_strap_mid(ddr_strap_mid), .ddr_strap_high(ddr_strap_high),
		.amplitude_strap(amplitude_strap), .cal_strap_mid(cal_strap_mid),
		.cal_strap_high(cal_strap_high), .range_strap(range_strap),
		.reg_write_q(reg_write_q), .header_error_q(header_error_q),
		.options_q(options_q)
	);

	cmfs_host_model cmfs_host_model_inst (
		.clk(clk), .sclk(sclk), .sdata(sdata), .scs_low(scs_low)
	);

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	always @(posedge clk) begin
		if (reg_write_q === 1'b1) wr_cnt++;
		if (header_error_q === 1'b1) err_cnt++;
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			final_report();
		end
	end

	task automatic final_report();
		if (fail_count == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic check(input string nm, input logic [79:0] e,
		input logic [79:0] g);
		tests_run++;
		if (e !== g) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask

	function automatic cmfs_pkg::cmfs_options_type model();
		cmfs_pkg::cmfs_options_type o;
		o = '0;
		o.ext_mode = !ctrl_mode_low;
		if (o.ext_mode) begin
			o.ddr_enable = !sh[1][10];
			o.output_data_clock_phase_select = sh[1][11];
			o.sdr_data_on_rising = sh[1][8];
			o.amplitude_normal = sh[1][9];
			o.dual_edge_sampling_enable = sh[9][13];
			o.dual_edge_q_input = sh[9][12];
			o.test_pattern_output = sh[9][15];
			o.output_data_clock_continuous = sh[9][14];
			o.demux_1to2 = !(o.ddr_enable && sh[1][8]);
			o.second_output_data_clock_enable = !sh[1][13];
			o.range_i = sh[3][15:7];
			o.range_q = sh[11][15:7];
			o.offset_i = sh[2][15:7];
			o.offset_q = sh[10][15:7];
			o.phase_coarse_mid = sh[15][15:7];
			o.phase_fine = sh[14][15:8];
		end else begin
			o.ddr_enable = ddr_strap_mid;
			o.sdr_data_on_rising = ddr_strap_high;
			o.amplitude_normal = amplitude_strap;
			o.cal_delay_long = cal_strap_high && !cal_strap_mid;
			o.range_reduced = !range_strap;
			o.dual_edge_sampling_enable = cal_strap_mid;
			o.demux_1to2 = 1'b1;
			o.range_i = 9'h100;
			o.range_q = 9'h100;
		end
		// Data edge is meaningless under DDR
		if (o.ddr_enable) o.sdr_data_on_rising = 1'b0;
		return o;
	endfunction

	task automatic chk_opts();
		exp_o = model();
		got_o = options_q;
		if (exp_o.ddr_enable) got_o.sdr_data_on_rising = 1'b0;
		check("options_q", {14'h0, exp_o}, {14'h0, got_o});
	endtask

	task automatic wr(input logic [3:0] a, input logic [15:0] d,
		input bit keep);
		cmfs_host_model_inst.send({12'h001, a, d}, 32, keep);
		if (!ctrl_mode_low) begin
			sh[a] = d;
			exp_wr++;
		end
	endtask

	task automatic do_reset(input logic mode);
		resetn = 1'b0;
		ctrl_mode_low = mode;
		tick(5);
		resetn = 1'b1;
		tick(6);
		sh = '{default: 16'h0};
		sh[1] = 16'hb2ff;
		sh[3] = 16'h8000;
		sh[11] = 16'h8000;
	endtask

	initial begin
		resetn = 1'b0;
		ctrl_mode_low = 1'b0;
		{ddr_strap_mid, ddr_strap_high, amplitude_strap} = 3'h7;
		{cal_strap_mid, cal_strap_high, range_strap} = 3'h1;
		fail_count = 0;
		tests_run = 0;
		wr_cnt = 0;
		err_cnt = 0;
		exp_wr = 0;
		cyc = 0;
		do_reset(1'b0);
		chk_opts();
		for (int i = 0; i < 4; i++) begin
			wr(4'h1, cfg1[i], 1'b0);
			tick(6);
			chk_opts();
		end
		for (int i = 0; i < 5; i++) begin
			wr(4'h9, cfg9[i], 1'b0);
			tick(6);
			chk_opts();
		end
		// Back-to-back adjust frames under one select
		for (int i = 0; i < 6; i++) begin
			wr(adr[i], adj[i], i < 5);
		end
		tick(6);
		chk_opts();
		wr(4'h4, 16'hffff, 1'b0);
		sh[4] = 16'h0;
		tick(6);
		chk_opts();
		cmfs_host_model_inst.send({12'h002, 4'h1, 16'h9dff}, 32, 1'b0);
		tick(6);
		chk_opts();
		check("header_error_q", 80'(1), 80'(err_cnt));
		cmfs_host_model_inst.send({12'h001, 4'h9, 16'h8000}, 31, 1'b0);
		tick(6);
		chk_opts();
		check("reg_write_q", 80'(exp_wr), 80'(wr_cnt));
		do_reset(1'b1);
		for (int i = 0; i < 3; i++) begin
			{ddr_strap_mid, ddr_strap_high, amplitude_strap, cal_strap_mid,
				cal_strap_high, range_strap} = straps[i];
			tick(6);
			chk_opts();
		end
		// Frame in pin mode must be ignored
		wr(4'h9, 16'he000, 1'b0);
		tick(6);
		chk_opts();
		check("reg_write_q", 80'(exp_wr), 80'(wr_cnt));
		final_report();
	end
endmodule
`default_nettype wire
